// ### hw/leiu_cfg.svh
`ifndef LEIU_CFG_SVH
`define LEIU_CFG_SVH

// register offsets
`define LEIU_ADDR_W 8
`define LEIU_OFS_FLAGS 8'h02
`define LEIU_OFS_ENABLE 8'h53
`define LEIU_OFS_STATUS 8'h60
`define LEIU_OFS_QWARN 8'h61
`define LEIU_OFS_LERR 8'h62

// field positions
`define LEIU_BIT_POL 7
`define LEIU_BIT_BROKEN 6
`define LEIU_BIT_QUAL 5
`define LEIU_BIT_XFER 4
`define LEIU_BIT_PIN 3
`define LEIU_BIT_LERR 2
`define LEIU_BIT_WAKE 1
`define LEIU_BIT_RSVD0 0

// masks and values
`define LEIU_FLAG_MASK 8'h7E
`define LEIU_CLEAR_ALL 8'h7F
`define LEIU_ENABLE_MASK 8'hFE
`define LEIU_RST_FLAGS 8'h00
`define LEIU_RST_ENABLE 8'h00
`define LEIU_RST_QWARN 8'h00
`define LEIU_RST_LERR 8'hFF
`define LEIU_QUAL_NONE_LOST 8'hFF

`endif

// ### hw/leiu_pkg.sv
`default_nettype none
package leiu_pkg;

  typedef struct packed {
    logic link_broken;
    logic xfer_done;
    logic wake_up;
  } leiu_pulse_t;

  typedef struct packed {
    logic [7:0] link_quality_count;
    logic [7:0] lost_packet_count;
    logic [3:0] remote_input_pins;
    logic [3:0] receiver_pin_register;
  } leiu_level_t;

  typedef enum logic {
    LEIU_ROLE_RX,
    LEIU_ROLE_TX
  } leiu_role_t;

  typedef enum {
    LEIU_PIN_IDLE,
    LEIU_PIN_ARMED
  } leiu_pin_state_t;

endpackage
`default_nettype wire

// ### hw/leiu_pin_change.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// pin change detector
// ------------------------------
module leiu_pin_change (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic [3:0] pins_i,
  output logic change_o
);
  import leiu_pkg::*;

  logic [3:0] last_reg;
  leiu_pin_state_t state_reg;

  // first sample after reset only arms, never reports
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_reg <= 4'h0;
      state_reg <= LEIU_PIN_IDLE;
      change_o <= 1'b0;
    end else if (enable_i) begin
      last_reg <= pins_i;
      case (state_reg)
        LEIU_PIN_IDLE: begin
          state_reg <= LEIU_PIN_ARMED;
          change_o <= 1'b0;
        end
        LEIU_PIN_ARMED: begin
          change_o <= (pins_i != last_reg);
        end
        default: begin
          state_reg <= LEIU_PIN_IDLE;
          change_o <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### hw/leiu_link_event_irq.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "leiu_cfg.svh"
// Function
// - irq stays active until the matching flag is cleared by writing a one or by a read
// - enable bit 7 picks irq polarity, one is active high
// - writing 0x7F to the flag register clears all flags
// - reading the flag register clears it and the pending irq
// - flag bit 6 marks link broken, enable bit 6 gates it
// - flag bit 5 set when quality count at or below warning threshold
// - flag bit 4 set when any remote transfer command completes
// - flag bit 3 set on remote or receiver pin value change
// - transmitter watches remote inputs, receiver watches its outputs
// - flag bit 2 set when lost count reaches error threshold
// - flag bit 1 set on wake from power down, enable bit 1
// - flag bits 7 and 0 reserved, enable bit 0 reads zero
// - outside wakeup mode only enabled flags can drive the irq pin
// - irq present in transmitter role, receiver only with slave interface
// - each unit has its own flags, enables and irq pin
// - wakeup enable blocks all other events from irq
// - with wakeup enabled irq shows power state
// - quality and transfer-done events exist only on the transmitter
// - quality count is 255 minus packets lost in 14 frames
// - lost count gives packets lost in 32 frames, 0 to 255
module leiu_link_event_irq (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire leiu_pkg::leiu_role_t role_i,
  input wire logic slave_if_i,
  input wire logic powered_up_i,
  input wire leiu_pkg::leiu_pulse_t pulse_i,
  input wire leiu_pkg::leiu_level_t level_i,
  input wire logic [3:0] pins_async_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic irq_oe_o
);
  import leiu_pkg::*;

  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [7:0] bit_mask(input int pos);
    bit_mask = 8'h01 << pos;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ------------------------------
  // pin synchroniser
  // ------------------------------
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else if (clk_en_i) begin
      pin_meta_reg <= pins_async_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ------------------------------
  // pin change source
  // ------------------------------
  logic [3:0] pin_src;
  logic pin_change;
  logic level_change;
  logic async_change;

  always_comb begin
    // transmitter: remote inputs; receiver: its pin register and outputs
    if (role_i == LEIU_ROLE_TX) begin
      pin_src = level_i.remote_input_pins;
    end else begin
      pin_src = level_i.receiver_pin_register;
    end
  end

  // two detectors, so changes on both sources in one cycle cannot cancel
  leiu_pin_change u_pin_change (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(clk_en_i),
    .pins_i(pin_src),
    .change_o(level_change)
  );

  leiu_pin_change u_async_change (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(clk_en_i),
    .pins_i(pin_sync_reg),
    .change_o(async_change)
  );

  assign pin_change = level_change || ((role_i == LEIU_ROLE_TX) && async_change);

  // ------------------------------
  // registers
  // ------------------------------
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] enable_reg;
  logic [7:0] qwarn_reg;
  logic [7:0] lerr_reg;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic qual_lvl;
  logic lerr_lvl;
  logic qual_last_reg;
  logic lerr_last_reg;
  logic is_tx;
  logic irq_active;
  logic irq_active_reg;
  logic irq_present;

  assign is_tx = (role_i == LEIU_ROLE_TX);
  // 255 means nothing lost, so low counts mean poor quality
  assign qual_lvl = (level_i.link_quality_count <= qwarn_reg);
  assign lerr_lvl = (level_i.lost_packet_count >= lerr_reg);

  // threshold events fire on entering the condition
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      qual_last_reg <= 1'b0;
      lerr_last_reg <= 1'b0;
    end else if (clk_en_i) begin
      qual_last_reg <= qual_lvl;
      lerr_last_reg <= lerr_lvl;
    end
  end

  always_comb begin
    set_vec = 8'h00;
    set_vec[`LEIU_BIT_BROKEN] = pulse_i.link_broken;
    set_vec[`LEIU_BIT_QUAL] = is_tx && qual_lvl && !qual_last_reg;
    set_vec[`LEIU_BIT_XFER] = is_tx && pulse_i.xfer_done;
    set_vec[`LEIU_BIT_PIN] = pin_change;
    set_vec[`LEIU_BIT_LERR] = lerr_lvl && !lerr_last_reg;
    set_vec[`LEIU_BIT_WAKE] = pulse_i.wake_up;
  end

  always_comb begin
    clr_vec = 8'h00;
    if (rd_i && hit(addr_i, `LEIU_OFS_FLAGS)) begin
      clr_vec = 8'hFF;
    end else if (wr_i && hit(addr_i, `LEIU_OFS_FLAGS)) begin
      if (wdata_i == `LEIU_CLEAR_ALL) begin
        clr_vec = 8'hFF;
      end else begin
        clr_vec = wdata_i;
      end
    end
    // set beats clear, reserved bits never hold
    flags_next = ((flags_reg & ~clr_vec) | set_vec) & `LEIU_FLAG_MASK;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_reg <= `LEIU_RST_FLAGS;
    end else if (clk_en_i) begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_reg <= `LEIU_RST_ENABLE;
      qwarn_reg <= `LEIU_RST_QWARN;
      lerr_reg <= `LEIU_RST_LERR;
    end else if (clk_en_i && wr_i) begin
      if (hit(addr_i, `LEIU_OFS_ENABLE)) begin
        enable_reg <= wdata_i & `LEIU_ENABLE_MASK;
      end
      if (hit(addr_i, `LEIU_OFS_QWARN)) begin
        qwarn_reg <= wdata_i;
      end
      if (hit(addr_i, `LEIU_OFS_LERR)) begin
        lerr_reg <= wdata_i;
      end
    end
  end

  // ------------------------------
  // read port
  // ------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      if (rd_i) begin
        case (addr_i)
          `LEIU_OFS_FLAGS: rdata_o <= flags_reg;
          `LEIU_OFS_ENABLE: rdata_o <= enable_reg;
          `LEIU_OFS_STATUS: rdata_o <= {5'h00, irq_active_reg, powered_up_i, is_tx};
          `LEIU_OFS_QWARN: rdata_o <= qwarn_reg;
          `LEIU_OFS_LERR: rdata_o <= lerr_reg;
          default: rdata_o <= 8'h00;
        endcase
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // ------------------------------
  // irq pin
  // ------------------------------

  always_comb begin
    if (enable_reg[`LEIU_BIT_WAKE]) begin
      irq_active = powered_up_i;
    end else begin
      irq_active = |(flags_reg & enable_reg & `LEIU_FLAG_MASK);
    end
  end

  assign irq_present = is_tx || slave_if_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_active_reg <= 1'b0;
      irq_o <= 1'b0;
      irq_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_active_reg <= irq_active;
      irq_o <= irq_active ~^ enable_reg[`LEIU_BIT_POL];
      irq_oe_o <= irq_present;
    end
  end

  // ------------------------------
  // checks
  // ------------------------------
  a_clear_all_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && wr_i && addr_i == `LEIU_OFS_FLAGS && wdata_i == `LEIU_CLEAR_ALL
     && set_vec == 8'h00) |=> (flags_reg == 8'h00))
    else $error("clear-all write left flags");

  a_read_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && rd_i && addr_i == `LEIU_OFS_FLAGS) |=> ((flags_reg & ~$past(set_vec)) == 8'h00))
    else $error("read did not clear flags");

  a_set_wins: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && set_vec[`LEIU_BIT_BROKEN]) |=> flags_reg[`LEIU_BIT_BROKEN])
    else $error("link broken event lost");

  a_flag_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && flags_reg[`LEIU_BIT_PIN] && !clr_vec[`LEIU_BIT_PIN])
    |=> flags_reg[`LEIU_BIT_PIN])
    else $error("pin flag dropped without clear");

  a_polarity_pin: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_n_i)
    |=> (irq_o == ($past(irq_active) == $past(enable_reg[`LEIU_BIT_POL]))))
    else $error("irq level wrong for polarity");

  a_disabled_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_n_i && (enable_reg & `LEIU_FLAG_MASK) == 8'h00)
    |=> (irq_o != $past(enable_reg[`LEIU_BIT_POL])))
    else $error("disabled flags drive irq");

  a_wake_power: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_n_i && enable_reg[`LEIU_BIT_WAKE])
    |=> (irq_o == ($past(powered_up_i) == $past(enable_reg[`LEIU_BIT_POL]))))
    else $error("irq not following power state");

  a_rx_no_quality: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!is_tx) |-> (!set_vec[`LEIU_BIT_QUAL] && !set_vec[`LEIU_BIT_XFER]))
    else $error("receiver raised transmitter event");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (flags_reg[7] == 1'b0 && flags_reg[0] == 1'b0 && enable_reg[0] == 1'b0))
    else $error("reserved bit set");

  a_oe_present: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && !is_tx && !slave_if_i) |=> !irq_oe_o)
    else $error("receiver drives irq without slave interface");

  a_oe_tx: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_n_i && is_tx)
    |=> irq_oe_o)
    else $error("transmitter irq pin not driven");

  a_read_data: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_n_i && rd_i && addr_i == `LEIU_OFS_FLAGS)
    |=> (rdata_o == $past(flags_reg)))
    else $error("flag read returned wrong value");

  a_pin_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_n_i && pin_change)
    |=> flags_reg[`LEIU_BIT_PIN])
    else $error("pin change not flagged");

  a_wake_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_n_i && pulse_i.wake_up)
    |=> flags_reg[`LEIU_BIT_WAKE])
    else $error("wakeup not flagged");

  a_xfer_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_n_i && is_tx && pulse_i.xfer_done)
    |=> flags_reg[`LEIU_BIT_XFER])
    else $error("transfer done not flagged");

  a_qual_entry: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_n_i && is_tx && qual_lvl && !qual_last_reg)
    |=> flags_reg[`LEIU_BIT_QUAL])
    else $error("poor quality not flagged");

  a_lerr_entry: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_n_i && lerr_lvl && !lerr_last_reg)
    |=> flags_reg[`LEIU_BIT_LERR])
    else $error("link error not flagged");

  a_enable_freeze: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (reset_n_i && !clk_en_i)
    |=> ($stable(flags_reg) && $stable(enable_reg) && $stable(irq_o)))
    else $error("state moved while clock enable low");

  // ------------------------------
  // coverage
  // ------------------------------

  c_read_clear: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    flags_reg != 8'h00 ##1 (rd_i && addr_i == `LEIU_OFS_FLAGS));
  c_irq_high: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    irq_active_reg && enable_reg[`LEIU_BIT_POL]);
  c_pin_change: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    pin_change && is_tx);
  c_wake_mode: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    enable_reg[`LEIU_BIT_WAKE] && !powered_up_i);
  c_set_over_clear: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    set_vec[`LEIU_BIT_BROKEN] && clr_vec[`LEIU_BIT_BROKEN]);

endmodule
`default_nettype wire

// ### testbench/leiu_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// controller watching the irq pin
// ------------------------------
module leiu_mcu_model (
  input wire logic irq_i,
  input wire logic irq_oe_i,
  input wire logic pol_i,
  output logic seen_o
);
  logic line;
  // pull-up holds a released line high
  assign line = irq_oe_i ? irq_i : 1'b1;
  assign seen_o = irq_oe_i && (line == pol_i);
endmodule
`default_nettype wire

// ### testbench/leiu_link_event_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "leiu_cfg.svh"
module leiu_link_event_irq_tb;
  import leiu_pkg::*;
  localparam logic [7:0] FL = `LEIU_OFS_FLAGS;
  localparam logic [7:0] EN = `LEIU_OFS_ENABLE;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic powered_up_i = 1'b1;
  logic slave_if_i = 1'b0;
  leiu_role_t role_i = LEIU_ROLE_TX;
  leiu_pulse_t pulse_i = '0;
  leiu_level_t level_i = 24'hFF0000;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic [3:0] pins_async_i = 4'h0;
  logic [7:0] rdata_o;
  logic irq_o;
  logic irq_oe_o;
  logic seen;
  logic pol = 1'b0;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  leiu_link_event_irq uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .role_i(role_i), .slave_if_i(slave_if_i), .powered_up_i(powered_up_i),
    .pulse_i(pulse_i), .level_i(level_i), .pins_async_i(pins_async_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .irq_oe_o(irq_oe_o));
  leiu_mcu_model mcu (.irq_i(irq_o), .irq_oe_i(irq_oe_o), .pol_i(pol), .seen_o(seen));
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic give_verdict();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    if (a == EN) begin
      pol <= d[7];
    end
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk8(rdata_o, exp);
  endtask
  task automatic pulse(input leiu_pulse_t p);
    @(posedge clk_i);
    pulse_i <= p;
    @(posedge clk_i);
    pulse_i <= '0;
    #1;
  endtask
  task automatic lvl(input leiu_level_t v);
    @(posedge clk_i);
    level_i <= v;
    tick(3);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wr(FL, `LEIU_CLEAR_ALL);
    chk1(irq_oe_o, 1'b1);
    rd(FL, 8'h00);
    rd(EN, 8'h00);
    rd(`LEIU_OFS_QWARN, 8'h00);
    rd(`LEIU_OFS_LERR, 8'hFF);
    rd(`LEIU_OFS_STATUS, 8'h03);
    rd(8'h10, 8'h00);
    wr(EN, 8'hFF);
    rd(EN, 8'hFE);
    wr(EN, 8'hC0);
    pulse(3'h4);
    tick(1);
    chk1(irq_o, 1'b1);
    chk1(seen, 1'b1);
    rd(FL, 8'h40);
    tick(1);
    chk1(irq_o, 1'b0);
    wr(EN, 8'hD0);
    pulse(3'h2);
    wr(FL, 8'h40);
    tick(1);
    chk1(irq_o, 1'b1);
    wr(FL, 8'h10);
    tick(1);
    chk1(irq_o, 1'b0);
    wr(EN, 8'h80);
    pulse(3'h4);
    tick(1);
    chk1(irq_o, 1'b0);
    rd(FL, 8'h40);
    wr(EN, 8'h40);
    tick(1);
    chk1(irq_o, 1'b1);
    pulse(3'h4);
    tick(1);
    chk1(irq_o, 1'b0);
    chk1(seen, 1'b1);
    wr(EN, 8'hC2);
    tick(1);
    chk1(irq_o, 1'b1);
    @(posedge clk_i);
    powered_up_i <= 1'b0;
    tick(2);
    chk1(irq_o, 1'b0);
    @(posedge clk_i);
    powered_up_i <= 1'b1;
    wr(FL, `LEIU_CLEAR_ALL);
    rd(FL, 8'h00);
    pulse(3'h1);
    rd(FL, 8'h02);
    pulse(3'h2);
    rd(FL, 8'h10);
    wr(`LEIU_OFS_QWARN, 8'h10);
    lvl(24'h110000);
    rd(FL, 8'h00);
    lvl(24'h100000);
    rd(FL, 8'h20);
    wr(`LEIU_OFS_LERR, 8'h20);
    lvl(24'h101F00);
    rd(FL, 8'h00);
    lvl(24'h102000);
    rd(FL, 8'h04);
    lvl(24'h102050);
    rd(FL, 8'h08);
    @(posedge clk_i);
    pins_async_i <= 4'h9;
    tick(5);
    rd(FL, 8'h08);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= FL;
    pulse_i <= 3'h4;
    @(posedge clk_i);
    rd_i <= 1'b0;
    pulse_i <= '0;
    #1;
    chk8(rdata_o, 8'h00);
    rd(FL, 8'h40);
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    pulse(3'h4);
    @(posedge clk_i);
    clk_en_i <= 1'b1;
    rd(FL, 8'h00);
    lvl(24'h102000);
    wr(FL, `LEIU_CLEAR_ALL);
    @(posedge clk_i);
    role_i <= LEIU_ROLE_RX;
    tick(2);
    chk1(irq_oe_o, 1'b0);
    @(posedge clk_i);
    slave_if_i <= 1'b1;
    tick(2);
    chk1(irq_oe_o, 1'b1);
    pulse(3'h2);
    lvl(24'hFF2000);
    lvl(24'h102000);
    rd(FL, 8'h00);
    lvl(24'h102003);
    rd(FL, 8'h08);
    give_verdict();
  end
endmodule
`default_nettype wire
